// >>> hdl/fdc_defines.svh
// Register offsets, opcodes, field positions, reset values and timing counts of the decoder.
`ifndef FDC_DEFINES_SVH
`define FDC_DEFINES_SVH
`define OFF_DATA 5'h00
`define OFF_STATUS 5'h04
`define OFF_CTRL 5'h08
`define OFF_INT_STAT 5'h0C
`define OFF_INT_MASK 5'h10
`define OFF_MODE 5'h14
`define OFF_SETUP 5'h18
`define OP_MODE 8'h01
`define OP_VENDOR_ID 8'h18
`define OP_PERP 8'h12
`define OP_RECAL 8'h07
`define OP5_READ 5'h06
`define OP5_READ_DEL 5'h0C
`define OP5_SCAN_EQ 5'h11
`define OP6_READ_ID 6'h0A
`define OP6_READ_TRK 6'h02
`define OP6_REL_SEEK 6'h0F
`define OP_DIR_BIT 6
// Identification byte value is arbitrary.
`define VENDOR_ID_BYTE 8'h5A
`define INVALID_SR0 8'h80
`define RESULT_LEN 3'd7
`define SR0_ABNORMAL 2'b01
`define SR1_OVERRUN 8'h10
`define SR2_SCAN_HIT 8'h08
`define SR2_SCAN_MISS 8'h04
`define SCAN_WILDCARD 8'hFF
`define MODE_RECAL_LONG_BIT 4
`define MODE_WILDCARD_BIT 4
`define RECAL_STEPS_SHORT 8'h50
`define RECAL_STEPS_LONG 8'hFF
`define SECTOR_BASE_BYTES 16'h0080
`define INT_RESULT 0
`define INT_SEEK 1
`define INT_XFER 2
`define RESET_MODE 32'h0000_0000
`define CLK_PERIOD_NS 5
`define STEP_TIME_NS 4000
`define STEP_PULSE_NS 100
`define STEP_CYCLES ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_PULSE_CYCLES ((`STEP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> hdl/fdc_pkg.sv
// Types of the floppy command decoder and its head stepper.
package fdc_pkg;
	typedef enum logic [2:0] {PH_CMD, PH_PARAM, PH_EXEC_RD, PH_EXEC_ID, PH_EXEC_SEEK,
		PH_RESULT} phase_t;
	typedef enum logic [3:0] {K_MODE, K_VID, K_PERP, K_READ, K_READ_DEL, K_READ_ID,
		K_READ_TRK, K_RECAL, K_RSEEK, K_SCAN, K_INVALID} kind_t;
	typedef struct packed {
		phase_t phase;
		kind_t kind;
		logic [3:0] need;
		logic [3:0] idx;
		logic [8:0][7:0] cmd;
		logic [6:0][7:0] res;
		logic [2:0] res_cnt;
		logic [2:0] res_idx;
		logic [3:0][7:0] mode;
		logic [7:0] perp;
		logic dma_mode;
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		logic irq;
		logic wait_req;
		logic [31:0] rdata;
		logic [3:0][7:0] track;
		logic [1:0] drive;
		logic head;
		logic [7:0] xbyte;
		logic xfull;
		logic [15:0] left;
		logic overrun;
		logic mismatch;
		logic [2:0] id_cnt;
		logic dma_req;
		logic [7:0] dma_wdata;
		logic t0_s1;
		logic t0_s2;
		logic st_start;
		logic [7:0] st_count;
	} dec_state_t;
	typedef struct packed {
		logic busy;
		logic [7:0] left;
		logic [15:0] timer;
		logic step;
		logic dir;
		logic done;
	} step_state_t;
endpackage

// >>> hdl/step_if.sv
// Handshake between the command decoder and the head stepper.
interface step_if;
	logic start;
	logic outward;
	logic stop_at_zero;
	logic [7:0] count;
	logic at_zero;
	logic done;
	modport ctl (output start, output outward, output stop_at_zero, output count,
		output at_zero, input done);
	modport drv (input start, input outward, input stop_at_zero, input count,
		input at_zero, output done);
endinterface

// >>> hdl/head_stepper.sv
// Step pulse generator that moves the selected head a counted number of tracks.
`include "fdc_defines.svh"
module head_stepper
	import fdc_pkg::*;
#(
	parameter int STEP_CYCLES = `STEP_CYCLES,
	parameter int PULSE_CYCLES = `STEP_PULSE_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	step_if.drv st,
	output logic step_o,
	output logic dir_o
);
	step_state_t s;
	step_state_t n;

	always_comb begin
		n = s;
		n.done = 1'b0;
		if (!s.busy) begin
			if (st.start) begin
				n.busy = 1'b1;
				n.left = st.count;
				n.dir = ~st.outward;
				n.timer = 16'h0000;
			end
		end else if (s.timer != 16'h0000) begin
			n.timer = s.timer - 16'h0001;
			if (s.timer == 16'(STEP_CYCLES - PULSE_CYCLES)) begin
				n.step = 1'b0;
			end
		end else if (s.left == 8'h00 || (st.stop_at_zero && st.at_zero)) begin
			// Recalibration stops early once the head reports track zero.
			n.busy = 1'b0;
			n.done = 1'b1;
			n.step = 1'b0;
		end else begin
			n.step = 1'b1;
			n.left = s.left - 8'h01;
			n.timer = 16'(STEP_CYCLES - 1);
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign st.done = s.done;
	assign step_o = s.step;
	assign dir_o = s.dir;
endmodule

// >>> hdl/floppy_command_decoder.sv
// Floppy command decoder with an Avalon-MM register port, DMA and programmed data transfer.
// Function
// - The vendor-identify opcode alone yields one fixed identification result byte.
// - The mode command takes four parameter bytes, stores them and returns no result.
// - The perpendicular command takes one parameter byte, stores it and returns no result.
// - Sector reads move disk bytes to the system by DMA or by programmed transfer.
// - Read-identifier reports the first identifier header found in seven result bytes.
// - Read-track takes the read layout, moves the track data and returns seven results.
// - Recalibrate steps the selected drive outward to track zero with no result.
// - Relative seek steps inward or outward by the given count with no result.
// - Scan-equal compares system bytes with disk bytes and returns seven results.
`include "fdc_defines.svh"
module floppy_command_decoder
	import fdc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	input wire logic [7:0] rd_byte_i,
	input wire logic rd_strobe_i,
	input wire logic rd_id_mark_i,
	input wire logic track0_i,
	output logic dma_req_o,
	output logic [7:0] dma_wdata_o,
	input wire logic dma_ack_i,
	input wire logic [7:0] dma_rdata_i,
	input wire logic dma_tc_i,
	output logic [1:0] drive_sel_o,
	output logic head_sel_o,
	output logic step_o,
	output logic dir_o
);
	dec_state_t s;
	dec_state_t n;
	logic req;
	logic go;
	logic wr_data;
	logic rd_data;
	logic [7:0] wbyte;
	logic exec_pio;
	logic is_scan;
	logic [7:0] status_byte;
	logic [2:0] int_set;
	logic [2:0] int_clr;
	logic launch;
	logic finish;
	logic [7:0] sys_byte;
	logic sys_valid;
	kind_t dec_kind;

	step_if st_bus();

	function automatic kind_t decode_op(input logic [7:0] op);
		if (op == `OP_MODE) begin
			decode_op = K_MODE;
		end else if (op == `OP_VENDOR_ID) begin
			decode_op = K_VID;
		end else if (op == `OP_PERP) begin
			decode_op = K_PERP;
		end else if (op == `OP_RECAL) begin
			decode_op = K_RECAL;
		end else if (op[4:0] == `OP5_READ) begin
			decode_op = K_READ;
		end else if (op[4:0] == `OP5_READ_DEL) begin
			decode_op = K_READ_DEL;
		end else if (op[4:0] == `OP5_SCAN_EQ) begin
			decode_op = K_SCAN;
		end else if (!op[7] && op[5:0] == `OP6_READ_ID) begin
			decode_op = K_READ_ID;
		end else if (!op[7] && op[5:0] == `OP6_READ_TRK) begin
			decode_op = K_READ_TRK;
		end else if (op[7] && op[5:0] == `OP6_REL_SEEK) begin
			decode_op = K_RSEEK;
		end else begin
			decode_op = K_INVALID;
		end
	endfunction

	function automatic logic [3:0] params_of(input kind_t k);
		case (k)
			K_MODE: params_of = 4'd4;
			K_PERP, K_READ_ID, K_RECAL: params_of = 4'd1;
			K_RSEEK: params_of = 4'd2;
			K_READ, K_READ_DEL, K_READ_TRK, K_SCAN: params_of = 4'd8;
			default: params_of = 4'd0;
		endcase
	endfunction

	assign req = avs_read_i | avs_write_i;
	assign go = req & ~s.wait_req;
	assign wbyte = avs_writedata_i[7:0];
	assign wr_data = go & avs_write_i & (avs_address_i == `OFF_DATA) & avs_byteenable_i[0];
	assign rd_data = go & avs_read_i & (avs_address_i == `OFF_DATA);
	assign is_scan = (s.kind == K_SCAN);
	assign exec_pio = (s.phase == PH_EXEC_RD) & ~s.dma_mode;
	assign dec_kind = decode_op(wbyte);
	// Main status: request-for-master, direction to host, programmed execution, busy, drive.
	assign status_byte = {(s.phase == PH_CMD) | (s.phase == PH_PARAM) | (s.phase == PH_RESULT)
		| (exec_pio & s.xfull), (s.phase == PH_RESULT) | (exec_pio & ~is_scan), exec_pio,
		s.phase != PH_CMD, 2'b00, s.drive};

	always_comb begin
		n = s;
		int_set = 3'b000;
		int_clr = 3'b000;
		launch = 1'b0;
		finish = 1'b0;
		sys_byte = 8'h00;
		sys_valid = 1'b0;
		n.wait_req = ~(req & s.wait_req);
		n.t0_s1 = track0_i;
		n.t0_s2 = s.t0_s1;
		n.st_start = 1'b0;
		if (req & s.wait_req & avs_read_i) begin
			if (avs_address_i == `OFF_DATA) begin
				n.rdata = {24'h00_0000, (s.phase == PH_RESULT) ? s.res[s.res_idx] : s.xbyte};
			end else if (avs_address_i == `OFF_STATUS) begin
				n.rdata = {24'h00_0000, status_byte};
			end else if (avs_address_i == `OFF_CTRL) begin
				n.rdata = {31'h0000_0000, s.dma_mode};
			end else if (avs_address_i == `OFF_INT_STAT) begin
				n.rdata = {29'h0000_0000, s.int_stat};
			end else if (avs_address_i == `OFF_INT_MASK) begin
				n.rdata = {29'h0000_0000, s.int_mask};
			end else if (avs_address_i == `OFF_MODE) begin
				n.rdata = s.mode;
			end else if (avs_address_i == `OFF_SETUP) begin
				n.rdata = {16'h0000, s.track[s.drive], s.perp};
			end else begin
				n.rdata = 32'h0000_0000;
			end
		end
		if (go & avs_write_i & avs_byteenable_i[0]) begin
			if (avs_address_i == `OFF_CTRL) begin
				n.dma_mode = wbyte[0];
			end else if (avs_address_i == `OFF_INT_MASK) begin
				n.int_mask = wbyte[2:0];
			end else if (avs_address_i == `OFF_INT_STAT) begin
				int_clr = wbyte[2:0];
			end
		end
		case (s.phase)
			PH_CMD: begin
				if (wr_data) begin
					n.cmd[0] = wbyte;
					n.kind = dec_kind;
					n.need = params_of(dec_kind);
					n.idx = 4'd0;
					n.res_idx = 3'd0;
					n.res_cnt = 3'd1;
					if (dec_kind == K_VID) begin
						n.res[0] = `VENDOR_ID_BYTE;
						n.phase = PH_RESULT;
						int_set[`INT_RESULT] = 1'b1;
					end else if (dec_kind == K_INVALID) begin
						n.res[0] = `INVALID_SR0;
						n.phase = PH_RESULT;
						int_set[`INT_RESULT] = 1'b1;
					end else begin
						n.phase = PH_PARAM;
					end
				end
			end
			PH_PARAM: begin
				if (wr_data) begin
					n.cmd[s.idx + 4'd1] = wbyte;
					n.idx = s.idx + 4'd1;
					launch = (s.idx + 4'd1 == s.need);
				end
			end
			PH_EXEC_RD: begin
				if (rd_strobe_i) begin
					if (s.xfull) begin
						n.overrun = 1'b1;
					end else begin
						n.xbyte = rd_byte_i;
						n.xfull = 1'b1;
						if (!is_scan) begin
							n.left = s.left - 16'h0001;
							n.dma_wdata = rd_byte_i;
						end
						n.dma_req = s.dma_mode;
						int_set[`INT_XFER] = ~s.dma_mode;
					end
				end
				if (s.dma_req & dma_ack_i) begin
					n.dma_req = 1'b0;
					n.xfull = 1'b0;
					sys_valid = is_scan;
					sys_byte = dma_rdata_i;
				end
				if (exec_pio & rd_data & ~is_scan) begin
					n.xfull = 1'b0;
				end
				if (exec_pio & wr_data & is_scan & s.xfull) begin
					n.xfull = 1'b0;
					sys_valid = 1'b1;
					sys_byte = wbyte;
				end
				if (sys_valid) begin
					n.left = s.left - 16'h0001;
					if (sys_byte != s.xbyte && !(s.mode[2][`MODE_WILDCARD_BIT]
						&& sys_byte == `SCAN_WILDCARD)) begin
						n.mismatch = 1'b1;
					end
				end
				finish = n.overrun | dma_tc_i | (n.left == 16'h0000 & ~n.xfull);
			end
			PH_EXEC_ID: begin
				if (rd_id_mark_i) begin
					n.id_cnt = 3'd1;
				end else if (s.id_cnt != 3'd0 && rd_strobe_i) begin
					n.res[s.id_cnt + 3'd2] = rd_byte_i;
					n.id_cnt = s.id_cnt + 3'd1;
					if (s.id_cnt == 3'd4) begin
						n.res[0] = {3'b000, 2'b00, s.head, s.drive};
						n.res[1] = 8'h00;
						n.res[2] = 8'h00;
						n.res_cnt = `RESULT_LEN;
						n.res_idx = 3'd0;
						n.phase = PH_RESULT;
						int_set[`INT_RESULT] = 1'b1;
					end
				end
			end
			PH_EXEC_SEEK: begin
				if (st_bus.done) begin
					if (s.kind == K_RECAL) begin
						n.track[s.drive] = 8'h00;
					end else if (s.cmd[0][`OP_DIR_BIT]) begin
						n.track[s.drive] = s.track[s.drive] + s.st_count;
					end else if (s.track[s.drive] > s.st_count) begin
						n.track[s.drive] = s.track[s.drive] - s.st_count;
					end else begin
						n.track[s.drive] = 8'h00;
					end
					n.phase = PH_CMD;
					int_set[`INT_SEEK] = 1'b1;
				end
			end
			PH_RESULT: begin
				if (rd_data) begin
					n.res_idx = s.res_idx + 3'd1;
					if (s.res_idx + 3'd1 == s.res_cnt) begin
						n.phase = PH_CMD;
					end
				end
			end
			default: n.phase = PH_CMD;
		endcase
		if (launch) begin
			n.drive = n.cmd[1][1:0];
			n.head = n.cmd[1][2];
			case (s.kind)
				K_MODE: begin
					n.mode = {n.cmd[4], n.cmd[3], n.cmd[2], n.cmd[1]};
					n.phase = PH_CMD;
				end
				K_PERP: begin
					n.perp = n.cmd[1];
					n.phase = PH_CMD;
				end
				K_READ_ID: begin
					n.id_cnt = 3'd0;
					n.phase = PH_EXEC_ID;
				end
				K_RECAL: begin
					n.head = 1'b0;
					n.st_start = 1'b1;
					n.st_count = s.mode[1][`MODE_RECAL_LONG_BIT] ? `RECAL_STEPS_LONG
						: `RECAL_STEPS_SHORT;
					n.phase = PH_EXEC_SEEK;
				end
				K_RSEEK: begin
					n.st_start = 1'b1;
					n.st_count = n.cmd[2];
					n.phase = PH_EXEC_SEEK;
				end
				default: begin
					// Size code zero lets the data length byte give the count, except for scan-equal.
					n.left = (s.kind != K_SCAN && n.cmd[5] == 8'h00) ? {8'h00, n.cmd[8]}
						: (`SECTOR_BASE_BYTES << n.cmd[5][2:0]);
					n.overrun = 1'b0;
					n.mismatch = 1'b0;
					n.xfull = 1'b0;
					n.dma_req = 1'b0;
					n.phase = PH_EXEC_RD;
				end
			endcase
		end
		if (finish) begin
			n.res[0] = {n.overrun ? `SR0_ABNORMAL : 2'b00, 3'b000, s.head, s.drive};
			n.res[1] = n.overrun ? `SR1_OVERRUN : 8'h00;
			n.res[2] = is_scan ? (n.mismatch ? `SR2_SCAN_MISS : `SR2_SCAN_HIT) : 8'h00;
			n.res[3] = s.cmd[2];
			n.res[4] = s.cmd[3];
			n.res[5] = s.cmd[4];
			n.res[6] = s.cmd[5];
			n.res_cnt = `RESULT_LEN;
			n.res_idx = 3'd0;
			n.dma_req = 1'b0;
			n.xfull = 1'b0;
			n.phase = PH_RESULT;
			int_set[`INT_RESULT] = 1'b1;
		end
		// A new event wins over a clear written in the same cycle.
		n.int_stat = (s.int_stat & ~int_clr) | int_set;
		n.irq = |(n.int_stat & n.int_mask);
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
			s.wait_req <= 1'b1;
			s.mode <= `RESET_MODE;
		end else begin
			s <= n;
		end
	end

	assign st_bus.start = s.st_start;
	assign st_bus.outward = (s.kind == K_RECAL) | ~s.cmd[0][`OP_DIR_BIT];
	assign st_bus.stop_at_zero = (s.kind == K_RECAL);
	assign st_bus.count = s.st_count;
	assign st_bus.at_zero = s.t0_s2;

	head_stepper u_stepper (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.st(st_bus),
		.step_o(step_o),
		.dir_o(dir_o)
	);

	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = s.wait_req;
	assign irq_o = s.irq;
	assign dma_req_o = s.dma_req;
	assign dma_wdata_o = s.dma_wdata;
	assign drive_sel_o = s.drive;
	assign head_sel_o = s.head;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	vendor_id_result_a: assert property (
		s.phase == PH_CMD && wr_data && wbyte == `OP_VENDOR_ID |=> s.phase == PH_RESULT
		&& s.res_cnt == 3'd1 && s.res[0] == `VENDOR_ID_BYTE)
		else $error("vendor identify did not give one id byte");
	mode_store_a: assert property (
		s.phase == PH_PARAM && s.kind == K_MODE && wr_data && s.idx == 4'd3
		|=> s.phase == PH_CMD && s.mode[3] == $past(wbyte))
		else $error("mode bytes not stored or result produced");
	perp_store_a: assert property (
		s.phase == PH_PARAM && s.kind == K_PERP && wr_data
		|=> s.phase == PH_CMD && s.perp == $past(wbyte))
		else $error("perpendicular byte not stored");
	read_decode_a: assert property (
		s.phase == PH_CMD && wr_data && wbyte[4:0] == `OP5_READ
		|=> s.kind == K_READ && s.need == 4'd8 && s.phase == PH_PARAM)
		else $error("read opcode not decoded");
	deleted_decode_a: assert property (
		s.phase == PH_CMD && wr_data && wbyte[4:0] == `OP5_READ_DEL
		|=> s.kind == K_READ_DEL && s.need == 4'd8)
		else $error("read deleted opcode not decoded");
	dma_ack_release_a: assert property (
		dma_req_o && dma_ack_i |=> !dma_req_o)
		else $error("dma request held after acknowledge");
	read_seven_results_a: assert property (
		s.phase == PH_EXEC_RD ##1 s.phase == PH_RESULT |-> s.res_cnt == 3'd7 && s.res_idx == 3'd0
		&& s.res[3] == s.cmd[2] && s.res[6] == s.cmd[5])
		else $error("read result is not seven bytes");
	read_id_result_a: assert property (
		s.phase == PH_EXEC_ID ##1 s.phase == PH_RESULT |-> s.res_cnt == 3'd7
		&& s.res[6] == $past(rd_byte_i))
		else $error("read id result wrong");
	track_decode_a: assert property (
		s.phase == PH_CMD && wr_data && !wbyte[7] && wbyte[5:0] == `OP6_READ_TRK
		|=> s.kind == K_READ_TRK && s.need == 4'd8)
		else $error("read track opcode not decoded");
	recal_outward_a: assert property (
		s.kind == K_RECAL && s.phase == PH_EXEC_SEEK && step_o |-> !dir_o)
		else $error("recalibrate stepped inward");
	seek_no_result_a: assert property (
		s.phase == PH_EXEC_SEEK ##1 s.phase != PH_EXEC_SEEK |-> s.phase == PH_CMD)
		else $error("seek produced a result phase");
	scan_status_a: assert property (
		s.kind == K_SCAN && s.phase == PH_EXEC_RD ##1 s.phase == PH_RESULT
		|-> s.res[2] == (s.mismatch ? `SR2_SCAN_MISS : `SR2_SCAN_HIT))
		else $error("scan status wrong");
	result_blocks_cmd_a: assert property (
		s.phase == PH_RESULT && wr_data |=> s.phase == PH_RESULT && $stable(s.res_idx))
		else $error("command accepted during result phase");
endmodule

// >>> testbench/dma_model.sv
// DMA controller model that answers disk-byte requests after a set delay.
module dma_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [7:0] wdata_i,
	input wire logic [3:0] delay_i,
	input wire logic [7:0] scan_byte_i,
	output logic ack_o,
	output logic [7:0] rdata_o,
	output logic [7:0] last_o,
	output logic [7:0] count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_r;
	logic hold_r;
	// The request is still high in the cycle after an ack, so that cycle is skipped.
	// Outside an ack the data line toggles, so a stale value is never mistaken for data.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			hold_r <= 1'b0;
			wait_r <= 4'h0;
			rdata_o <= 8'h00;
			last_o <= 8'h00;
			count_o <= 8'h00;
		end else if (ack_o) begin
			ack_o <= 1'b0;
			hold_r <= 1'b1;
			rdata_o <= ~rdata_o;
		end else begin
			hold_r <= 1'b0;
			rdata_o <= ~rdata_o;
			if (req_i && !hold_r && wait_r == delay_i) begin
				ack_o <= 1'b1;
				rdata_o <= scan_byte_i;
				last_o <= wdata_i;
				count_o <= count_o + 8'h01;
				wait_r <= 4'h0;
			end else if (req_i && !hold_r) begin
				wait_r <= wait_r + 4'h1;
			end else begin
				wait_r <= 4'h0;
			end
		end
	end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench of the floppy command decoder with a DMA partner.
`include "fdc_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		int n;
		logic [7:0] b [5];
		logic [4:0] a;
		logic [31:0] e;
	} row_t;
	logic core_clk_i, rst_i, avs_read_i, avs_write_i, rd_strobe_i, rd_id_mark_i, track0_i;
	logic avs_waitrequest_o, irq_o, dma_req_o, dma_ack_i, step_o, dir_o, head_sel_o, step_d;
	logic [4:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rdv;
	logic [7:0] rd_byte_i, dma_wdata_o, dma_rdata_i, scan_byte, dma_last, dma_count, n0;
	logic [3:0] dma_delay;
	logic dma_tc;
	logic [1:0] drive_sel_o;
	logic [7:0] res [7];
	int miscompares, samples_checked, steps, pos;
	row_t rows [4];
	floppy_command_decoder dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.irq_o(irq_o), .rd_byte_i(rd_byte_i), .rd_strobe_i(rd_strobe_i),
		.rd_id_mark_i(rd_id_mark_i), .track0_i(track0_i), .dma_req_o(dma_req_o),
		.dma_wdata_o(dma_wdata_o), .dma_ack_i(dma_ack_i), .dma_rdata_i(dma_rdata_i),
		.dma_tc_i(dma_tc), .drive_sel_o(drive_sel_o), .head_sel_o(head_sel_o),
		.step_o(step_o), .dir_o(dir_o));
	dma_model dma_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(dma_req_o),
		.wdata_i(dma_wdata_o), .delay_i(dma_delay), .scan_byte_i(scan_byte),
		.ack_o(dma_ack_i), .rdata_o(dma_rdata_i), .last_o(dma_last), .count_o(dma_count));
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	// Drive position model: counts step pulses and reports track zero to the design.
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			step_d <= 1'b0;
			steps <= 0;
			pos <= 0;
			track0_i <= 1'b1;
		end else begin
			step_d <= step_o;
			if (step_o && !step_d) begin
				steps <= steps + 1;
				pos <= dir_o ? pos + 1 : pos - 1;
			end
			track0_i <= (pos == 0);
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 100);
		rdv = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n >= 100) begin
			check("waitrequest timeout", 32'h0000_0000, 32'h0000_0001);
			finish_test();
		end
	endtask
	task automatic wait_int(input int b, input logic exp_irq);
		int n;
		n = 0;
		do begin
			bus(0, `OFF_INT_STAT, 32'h0000_0000);
			n++;
		end while (rdv[b] !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			check("interrupt timeout", 32'h0000_0000, 32'h0000_0001);
			finish_test();
		end
		@(posedge core_clk_i);
		check("irq raised or masked", 32'(irq_o), 32'(exp_irq));
		bus(1, `OFF_INT_STAT, 32'(1 << b));
		repeat (2) @(posedge core_clk_i);
		check("irq cleared", 32'(irq_o), 32'h0000_0000);
	endtask
	task automatic send(input logic [7:0] b [9], input int n);
		for (int i = 0; i < n; i++) begin
			bus(1, `OFF_DATA, 32'(b[i]));
		end
	endtask
	task automatic get_results(input int n);
		for (int i = 0; i < n; i++) begin
			bus(0, `OFF_DATA, 32'h0000_0000);
			res[i] = rdv[7:0];
		end
		bus(0, `OFF_STATUS, 32'h0000_0000);
		check("idle after results", 32'(rdv[4]), 32'h0000_0000);
	endtask
	task automatic disk(input logic [7:0] b, input int gap);
		@(posedge core_clk_i);
		rd_byte_i <= b;
		rd_strobe_i <= 1'b1;
		@(posedge core_clk_i);
		rd_strobe_i <= 1'b0;
		repeat (gap) @(posedge core_clk_i);
	endtask
	task automatic seek(input logic [7:0] op, input logic [7:0] cnt, input int exp_steps,
		input logic [7:0] exp_trk);
		int s0;
		s0 = steps;
		send('{op, 8'h00, cnt, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, op == `OP_RECAL ? 2 : 3);
		wait_int(1, 1'b0);
		check("step count", 32'(steps - s0), 32'(exp_steps));
		bus(0, `OFF_SETUP, 32'h0000_0000);
		check("present track", 32'(rdv[15:8]), 32'(exp_trk));
	endtask
	task automatic scan(input logic [7:0] sys, input logic [7:0] sr2);
		scan_byte <= sys;
		send('{8'h11, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1B, 8'h01}, 9);
		for (int i = 0; i < 128; i++) begin
			disk(8'h3C, 8);
		end
		wait_int(0, 1'b1);
		get_results(7);
		check("scan status 2", 32'(res[2]), 32'(sr2));
	endtask
	initial begin
		rst_i = 1'b1;
		avs_address_i = 5'h00;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0000_0000;
		rd_byte_i = 8'h00;
		rd_strobe_i = 1'b0;
		rd_id_mark_i = 1'b0;
		scan_byte = 8'h00;
		dma_delay = 4'h2;
		dma_tc = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		rows[0] = '{2, '{8'h12, 8'hA5, 8'h00, 8'h00, 8'h00}, `OFF_SETUP, 32'h0000_00A5};
		rows[1] = '{5, '{8'h01, 8'hA1, 8'h22, 8'h43, 8'h84}, `OFF_MODE, 32'h8443_22A1};
		rows[2] = '{1, '{8'h18, 8'h00, 8'h00, 8'h00, 8'h00}, `OFF_DATA, 32'h0000_005A};
		rows[3] = '{1, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, `OFF_DATA, 32'h0000_0080};
		repeat (8) @(posedge core_clk_i);
		check("reset outputs", {avs_waitrequest_o, irq_o, dma_req_o, step_o}, 32'h0000_0008);
		rst_i <= 1'b0;
		bus(0, `OFF_MODE, 32'h0000_0000);
		check("mode reset", rdv, `RESET_MODE);
		bus(0, 5'h1C, 32'h0000_0000);
		check("unmapped read", rdv, 32'h0000_0000);
		foreach (rows[r]) begin
			for (int j = 0; j < rows[r].n; j++) begin
				bus(1, `OFF_DATA, 32'(rows[r].b[j]));
			end
			bus(0, rows[r].a, 32'h0000_0000);
			check("row result", rdv, rows[r].e);
			bus(0, `OFF_STATUS, 32'h0000_0000);
			check("row idle", 32'(rdv[4]), 32'h0000_0000);
		end
		// A byte written while a result is pending must not start a command.
		bus(1, `OFF_DATA, 32'h0000_0018);
		bus(1, `OFF_DATA, 32'h0000_0001);
		bus(0, `OFF_DATA, 32'h0000_0000);
		check("id under refusal", rdv, 32'h0000_005A);
		bus(1, `OFF_DATA, 32'h0000_0018);
		bus(0, `OFF_DATA, 32'h0000_0000);
		check("id after refusal", rdv, 32'h0000_005A);
		bus(1, `OFF_INT_STAT, 32'h0000_0007);
		bus(1, `OFF_INT_MASK, 32'h0000_0001);
		bus(1, `OFF_CTRL, 32'h0000_0001);
		n0 = dma_count;
		send('{8'hE6, 8'h05, 8'h03, 8'h01, 8'h04, 8'h00, 8'h04, 8'h1B, 8'h04}, 9);
		// The launch edge is the one the last write returned on, so let it settle.
		@(posedge core_clk_i);
		check("drive and head", 32'({drive_sel_o, head_sel_o}), 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			disk(8'(8'h90 + i), 10);
		end
		wait_int(0, 1'b1);
		check("dma count", 32'(dma_count - n0), 32'h0000_0004);
		check("dma last", 32'(dma_last), 32'h0000_0093);
		get_results(7);
		check("read chn", {res[3], res[4], res[6]}, 32'h0003_0100);
		// Terminal count ends a long read early with a normal status.
		send('{8'h06, 8'h02, 8'h07, 8'h00, 8'h03, 8'h01, 8'h04, 8'h1B, 8'h00}, 9);
		disk(8'h55, 10);
		dma_tc <= 1'b1;
		@(posedge core_clk_i);
		dma_tc <= 1'b0;
		wait_int(0, 1'b1);
		get_results(7);
		check("tc end", {res[0], res[1], res[6]}, 32'h0002_0001);
		dma_delay <= 4'hF;
		send('{8'h4C, 8'h01, 8'h05, 8'h00, 8'h02, 8'h00, 8'h09, 8'h1B, 8'h10}, 9);
		disk(8'h11, 1);
		disk(8'h22, 1);
		wait_int(0, 1'b1);
		get_results(7);
		check("overrun", {res[0][7:6], res[1]}, {2'b01, 8'h10});
		send('{8'h4A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
		@(posedge core_clk_i);
		rd_id_mark_i <= 1'b1;
		@(posedge core_clk_i);
		rd_id_mark_i <= 1'b0;
		disk(8'h11, 2);
		disk(8'h00, 2);
		disk(8'h07, 2);
		disk(8'h02, 2);
		wait_int(0, 1'b1);
		get_results(7);
		check("id fields", {res[3], res[4], res[5], res[6]}, 32'h1100_0702);
		bus(1, `OFF_CTRL, 32'h0000_0000);
		send('{8'h42, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1B, 8'h02}, 9);
		for (int i = 0; i < 2; i++) begin
			disk(8'(8'hC0 + i), 2);
			wait_int(2, 1'b0);
			bus(0, `OFF_DATA, 32'h0000_0000);
			check("pio byte", 32'(rdv[7:0]), 32'(8'hC0 + i));
		end
		wait_int(0, 1'b1);
		get_results(7);
		check("track size", 32'(res[6]), 32'h0000_0000);
		bus(1, `OFF_CTRL, 32'h0000_0001);
		dma_delay <= 4'h1;
		scan(8'h3C, 8'h08);
		scan(8'h3D, 8'h04);
		// Mode byte three bit four lets an all-ones system byte match anything.
		send('{8'h01, 8'hA1, 8'h22, 8'h53, 8'h84, 8'h00, 8'h00, 8'h00, 8'h00}, 5);
		scan(8'hFF, 8'h08);
		seek(8'hCF, 8'h03, 3, 8'h03);
		seek(8'h8F, 8'h01, 1, 8'h02);
		check("outward dir", 32'(dir_o), 32'h0000_0000);
		seek(8'h07, 8'h00, 2, 8'h00);
		finish_test();
	end
endmodule
